// *** shared/ptc_pkg.sv ***
// Package for the paired timer control block: offsets, fields, resets, types.
// Assumes an APB slave with 32-bit data, one aligned word per register.
package ptc_pkg;
  // Register byte offsets
  localparam logic [7:0] PTC_OFF_LO_CTRL = 8'h00;
  localparam logic [7:0] PTC_OFF_HI_CTRL = 8'h04;
  localparam logic [7:0] PTC_OFF_LO_CNT = 8'h08;
  localparam logic [7:0] PTC_OFF_HI_CNT = 8'h0c;
  localparam logic [7:0] PTC_OFF_LO_PER = 8'h10;
  localparam logic [7:0] PTC_OFF_HI_PER = 8'h14;
  localparam logic [7:0] PTC_OFF_STATUS = 8'h18;
  // Control field positions
  localparam int PTC_BIT_RUN = 15;
  localparam int PTC_BIT_HALT_IDLE = 13;
  localparam int PTC_BIT_GATE = 6;
  localparam int PTC_BIT_PS_HI = 5;
  localparam int PTC_BIT_PS_LO = 4;
  localparam int PTC_BIT_PAIR = 3;
  localparam int PTC_BIT_CLK_SRC = 1;
  // Writable bits of each control register
  localparam logic [15:0] PTC_LO_CTRL_MASK = 16'ha07a;
  localparam logic [15:0] PTC_HI_CTRL_MASK = 16'ha072;
  // Reset values
  localparam logic [15:0] PTC_CTRL_RST = 16'h0000;
  localparam logic [15:0] PTC_CNT_RST = 16'h0000;
  localparam logic [15:0] PTC_PER_RST = 16'hffff;
  // Prescale terminal counts (divide minus one)
  localparam logic [7:0] PTC_DIV1_TC = 8'h00;
  localparam logic [7:0] PTC_DIV8_TC = 8'h07;
  localparam logic [7:0] PTC_DIV64_TC = 8'h3f;
  localparam logic [7:0] PTC_DIV256_TC = 8'hff;
  // Internal clock is the system clock divided by two
  localparam logic PTC_INT_DIV_TC = 1'b1;

  typedef struct packed {
    logic run;
    logic halt_idle;
    logic gate;
    logic [1:0] prescale;
    logic pair;
    logic clk_src;
  } ptc_ctrl_t;

  function automatic ptc_ctrl_t ptc_decode(input logic [15:0] w);
    ptc_ctrl_t c;
    c.run = w[PTC_BIT_RUN];
    c.halt_idle = w[PTC_BIT_HALT_IDLE];
    c.gate = w[PTC_BIT_GATE];
    c.prescale = w[PTC_BIT_PS_HI:PTC_BIT_PS_LO];
    c.pair = w[PTC_BIT_PAIR];
    c.clk_src = w[PTC_BIT_CLK_SRC];
    return c;
  endfunction
endpackage

// *** rtl/ptc_pin_sync.sv ***
// Three-stage synchroniser with edge and level outputs for a pin input.
// Assumes the pin is asynchronous to i_sys_clk.
`timescale 1ns/100ps
`default_nettype none
module ptc_pin_sync (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Pin in, conditioned out
  input wire logic i_pin,
  output logic o_level,
  output logic o_rise
);
  logic [2:0] sync_r;
  logic level_r;
  logic rise_r;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync_r <= 3'h0;
    end else begin
      sync_r <= {sync_r[1:0], i_pin};
    end
  end

  // Accept a change only once stages two and three agree
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      level_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      rise_r <= 1'b0;
      if (sync_r[2] == sync_r[1] && sync_r[2] != level_r) begin
        level_r <= sync_r[2];
        rise_r <= sync_r[2];
      end
    end
  end

  assign o_level = level_r;
  assign o_rise = rise_r;
endmodule
`default_nettype wire

// *** rtl/ptc_prescaler.sv ***
// Prescaler: passes one of every 1, 8, 64 or 256 input ticks.
// Assumes a single-cycle clear from the control write logic.
`timescale 1ns/100ps
`default_nettype none
module ptc_prescaler (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Control
  input wire logic i_clear,
  input wire logic [1:0] i_select,
  // Ticks
  input wire logic i_tick,
  output logic o_tick
);
  import ptc_pkg::*;
  logic [7:0] cnt_r;
  logic [7:0] term;

  always_comb begin
    unique case (i_select)
      2'b00: term = PTC_DIV1_TC;
      2'b01: term = PTC_DIV8_TC;
      2'b10: term = PTC_DIV64_TC;
      2'b11: term = PTC_DIV256_TC;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r <= 8'h00;
    end else if (i_clear) begin
      cnt_r <= 8'h00;
    end else if (i_tick) begin
      cnt_r <= (cnt_r >= term) ? 8'h00 : cnt_r + 8'h01;
    end
  end

  assign o_tick = i_tick && (cnt_r >= term);
endmodule
`default_nettype wire

// *** rtl/ptc_top.sv ***
// Paired 16-bit timer control with 32-bit join, APB register access.
// Assumes an APB master on i_sys_clk and asynchronous clock/gate pins.
`timescale 1ns/100ps
`default_nettype none
module ptc_top (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Device state and pins
  input wire logic i_idle,
  input wire logic i_lo_ext_clk,
  input wire logic i_lo_gate,
  input wire logic i_hi_ext_clk,
  input wire logic i_hi_gate,
  // Period match flags, level
  output logic o_lo_match,
  output logic o_hi_match
);
  import ptc_pkg::*;

  logic rst_s1_r, rst_b_r;
  logic [15:0] lo_ctrl_r, hi_ctrl_r;
  logic [15:0] lo_cnt_r, hi_cnt_r, lo_per_r, hi_per_r;
  logic lo_flag_r, hi_flag_r, div2_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;
  ptc_ctrl_t lc, hc;
  logic pair;
  logic lo_ext_rise, lo_gate_lvl, hi_ext_rise, hi_gate_lvl;
  logic wr, rd, wr_lo_ctrl, wr_hi_ctrl, lo_raw, hi_raw, lo_tick, hi_tick, lo_clr, hi_clr;
  logic lo_wrap, hi_wrap, wide_match;

  // Reset release
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_s1_r <= 1'b0;
      rst_b_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_b_r <= rst_s1_r;
    end
  end

  ptc_pin_sync u_lo_clk (.i_sys_clk(i_sys_clk), .i_rst_b(rst_b_r), .i_pin(i_lo_ext_clk),
    .o_level(), .o_rise(lo_ext_rise));
  ptc_pin_sync u_lo_gate (.i_sys_clk(i_sys_clk), .i_rst_b(rst_b_r), .i_pin(i_lo_gate),
    .o_level(lo_gate_lvl), .o_rise());
  ptc_pin_sync u_hi_clk (.i_sys_clk(i_sys_clk), .i_rst_b(rst_b_r), .i_pin(i_hi_ext_clk),
    .o_level(), .o_rise(hi_ext_rise));
  ptc_pin_sync u_hi_gate (.i_sys_clk(i_sys_clk), .i_rst_b(rst_b_r), .i_pin(i_hi_gate),
    .o_level(hi_gate_lvl), .o_rise());

  assign lc = ptc_decode(lo_ctrl_r);
  assign hc = ptc_decode(hi_ctrl_r);
  assign pair = lc.pair;

  // APB decode: one-wait-state slave, answer at second access cycle
  assign wr = i_psel && i_penable && i_pwrite && !pready_r;
  assign rd = i_psel && i_penable && !i_pwrite && !pready_r;
  assign wr_lo_ctrl = wr && (i_paddr == PTC_OFF_LO_CTRL);
  assign wr_hi_ctrl = wr && (i_paddr == PTC_OFF_HI_CTRL);

  always_ff @(posedge i_sys_clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= i_psel && i_penable && !pready_r;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      if (rd) begin
        unique case (i_paddr)
          PTC_OFF_LO_CTRL: prdata_r <= {16'h0000, lo_ctrl_r};
          PTC_OFF_HI_CTRL: prdata_r <= {16'h0000, hi_ctrl_r};
          PTC_OFF_LO_CNT: prdata_r <= {16'h0000, lo_cnt_r};
          PTC_OFF_HI_CNT: prdata_r <= {16'h0000, hi_cnt_r};
          PTC_OFF_LO_PER: prdata_r <= {16'h0000, lo_per_r};
          PTC_OFF_HI_PER: prdata_r <= {16'h0000, hi_per_r};
          PTC_OFF_STATUS: prdata_r <= {30'h0, hi_flag_r, lo_flag_r};
          default: pslverr_r <= 1'b1;
        endcase
      end else if (wr) begin
        if (!(i_paddr inside {PTC_OFF_LO_CTRL, PTC_OFF_HI_CTRL, PTC_OFF_LO_CNT,
            PTC_OFF_HI_CNT, PTC_OFF_LO_PER, PTC_OFF_HI_PER, PTC_OFF_STATUS})) begin
          pslverr_r <= 1'b1;
        end
      end
    end
  end

  // Control registers, unimplemented bits forced to zero
  always_ff @(posedge i_sys_clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      lo_ctrl_r <= PTC_CTRL_RST;
      hi_ctrl_r <= PTC_CTRL_RST;
    end else begin
      if (wr_lo_ctrl) begin
        lo_ctrl_r <= i_pwdata[15:0] & PTC_LO_CTRL_MASK;
      end
      if (wr_hi_ctrl) begin
        hi_ctrl_r <= i_pwdata[15:0] & PTC_HI_CTRL_MASK;
      end
    end
  end

  // Period registers
  always_ff @(posedge i_sys_clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      lo_per_r <= PTC_PER_RST;
      hi_per_r <= PTC_PER_RST;
    end else begin
      if (wr && i_paddr == PTC_OFF_LO_PER) begin
        lo_per_r <= i_pwdata[15:0];
      end
      if (wr && i_paddr == PTC_OFF_HI_PER) begin
        hi_per_r <= i_pwdata[15:0];
      end
    end
  end

  // Internal count clock at half the system rate
  always_ff @(posedge i_sys_clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      div2_r <= 1'b0;
    end else begin
      div2_r <= (div2_r == PTC_INT_DIV_TC) ? 1'b0 : 1'b1;
    end
  end

  // Raw count ticks before prescaling
  always_comb begin
    lo_raw = 1'b0;
    if (lc.run && !(lc.halt_idle && i_idle)) begin
      if (lc.clk_src) begin
        lo_raw = lo_ext_rise;
      end else begin
        lo_raw = div2_r && (!lc.gate || lo_gate_lvl);
      end
    end
    hi_raw = 1'b0;
    if (!pair && hc.run && !(hc.halt_idle && i_idle)) begin
      if (hc.clk_src) begin
        hi_raw = hi_ext_rise;
      end else begin
        hi_raw = div2_r && (!hc.gate || hi_gate_lvl);
      end
    end
  end

  // Control write while running clears the prescaler
  assign lo_clr = wr_lo_ctrl && lc.run;
  assign hi_clr = wr_hi_ctrl && hc.run && !pair;

  ptc_prescaler u_lo_ps (.i_sys_clk(i_sys_clk), .i_rst_b(rst_b_r), .i_clear(lo_clr),
    .i_select(lc.prescale), .i_tick(lo_raw), .o_tick(lo_tick));
  ptc_prescaler u_hi_ps (.i_sys_clk(i_sys_clk), .i_rst_b(rst_b_r), .i_clear(hi_clr),
    .i_select(hc.prescale), .i_tick(hi_raw), .o_tick(hi_tick));

  assign wide_match = {hi_cnt_r, lo_cnt_r} == {hi_per_r, lo_per_r};
  assign lo_wrap = (lo_cnt_r == lo_per_r);
  assign hi_wrap = (hi_cnt_r == hi_per_r);

  // Counters: low word always from low tick; high word carries in pair mode
  always_ff @(posedge i_sys_clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      lo_cnt_r <= PTC_CNT_RST;
      hi_cnt_r <= PTC_CNT_RST;
    end else if (pair) begin
      if (lo_tick) begin
        if (wide_match) begin
          lo_cnt_r <= PTC_CNT_RST;
          hi_cnt_r <= PTC_CNT_RST;
        end else begin
          {hi_cnt_r, lo_cnt_r} <= {hi_cnt_r, lo_cnt_r} + 32'h0000_0001;
        end
      end
    end else begin
      if (wr && i_paddr == PTC_OFF_LO_CNT) begin
        lo_cnt_r <= i_pwdata[15:0];
      end else if (lo_tick) begin
        lo_cnt_r <= lo_wrap ? PTC_CNT_RST : lo_cnt_r + 16'h0001;
      end
      if (wr && i_paddr == PTC_OFF_HI_CNT) begin
        hi_cnt_r <= i_pwdata[15:0];
      end else if (hi_tick) begin
        hi_cnt_r <= hi_wrap ? PTC_CNT_RST : hi_cnt_r + 16'h0001;
      end
    end
  end

  // Match flags: set wins over a write-one clear
  always_ff @(posedge i_sys_clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      lo_flag_r <= 1'b0;
      hi_flag_r <= 1'b0;
    end else begin
      if (!pair && lo_tick && lo_wrap) begin
        lo_flag_r <= 1'b1;
      end else if (wr && i_paddr == PTC_OFF_STATUS && i_pwdata[0]) begin
        lo_flag_r <= 1'b0;
      end
      if ((pair && lo_tick && wide_match) || (!pair && hi_tick && hi_wrap)) begin
        hi_flag_r <= 1'b1;
      end else if (wr && i_paddr == PTC_OFF_STATUS && i_pwdata[1]) begin
        hi_flag_r <= 1'b0;
      end
    end
  end

  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_lo_match = lo_flag_r;
  assign o_hi_match = hi_flag_r;
endmodule
`default_nettype wire

// *** verif/ptc_pin_model.sv ***
// External count pin and gate pin source for one timer.
// Assumes pulses are asynchronous to the system clock.
`timescale 1ns/100ps
`default_nettype none
module ptc_pin_model (
  // Pins
  output logic o_clk,
  output logic o_gate
);
  initial begin
    o_clk = 1'b0;
    o_gate = 1'b0;
  end
  // Clock rests low between bursts; pin mapping is fixed here
  task automatic pulses(input int n);
    repeat (n) begin
      // Both edges kept clear of the system clock edge
      #170 o_clk = ~o_clk;
      #220 o_clk = ~o_clk;
      #10;
    end
  endtask
  task automatic set_gate(input logic v);
    #10 o_gate = v;
  endtask
endmodule
`default_nettype wire

// *** verif/ptc_checker.sv ***
// Port checker for the paired timer control block.
// Assumes a bind into ptc_top and a master that holds requests.
`timescale 1ns/100ps
`default_nettype none
module ptc_checker
  import ptc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_lo_match,
  input wire logic o_hi_match
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  logic mapped, acc, clr_st, rd_lo, rd_hi;
  assign mapped = i_paddr <= PTC_OFF_STATUS && i_paddr[1:0] == 2'h0;
  assign acc = i_psel && i_penable;
  assign clr_st = i_psel && i_pwrite && i_paddr == PTC_OFF_STATUS;
  assign rd_lo = o_pready && !i_pwrite && i_paddr == PTC_OFF_LO_CTRL;
  assign rd_hi = o_pready && !i_pwrite && i_paddr == PTC_OFF_HI_CTRL;
  one_wait_a: assert property ($rose(i_penable) && i_psel |=> o_pready)
    else $error("pready not one cycle after access");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  ready_cause_a: assert property (o_pready |-> $past(acc))
    else $error("pready without access");
  data_idle_a: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside answer");
  err_map_a: assert property ($rose(i_penable) && i_psel |=> o_pslverr == !mapped)
    else $error("slave error does not match decode");
  lo_mask_a: assert property (rd_lo |-> (o_prdata & ~{16'h0, PTC_LO_CTRL_MASK}) == 0)
    else $error("low control unimplemented bits set");
  hi_mask_a: assert property (rd_hi |-> (o_prdata & ~{16'h0, PTC_HI_CTRL_MASK}) == 0)
    else $error("high control unimplemented bits set");
  lo_sticky_a: assert property (o_lo_match && !clr_st |=> o_lo_match)
    else $error("low flag dropped by itself");
  hi_sticky_a: assert property (o_hi_match && !clr_st |=> o_hi_match)
    else $error("high flag dropped by itself");
  cover property (o_pslverr);
  cover property ($rose(o_lo_match));
  cover property ($rose(o_hi_match));
endmodule
bind ptc_top ptc_checker u_chk (.i_sys_clk, .i_rst_b, .i_psel, .i_penable, .i_pwrite,
  .i_paddr, .o_prdata, .o_pready, .o_pslverr, .o_lo_match, .o_hi_match);
`default_nettype wire

// *** verif/ptc_tb_top.sv ***
// Self-checking bench: APB master, pin models, random control values.
// Assumes the package, design and checker bind are compiled first.
`timescale 1ns/100ps
`default_nettype none
module ptc_tb_top;
  import ptc_pkg::*;
  logic i_sys_clk, i_rst_b, i_psel, i_penable, i_pwrite, i_idle, e;
  logic [7:0] i_paddr, a;
  logic [31:0] i_pwdata, o_prdata, rd, v, seed;
  logic o_pready, o_pslverr, o_lo_match, o_hi_match;
  logic i_lo_ext_clk, i_lo_gate, i_hi_ext_clk, i_hi_gate;
  logic [15:0] ctab [4] = '{16'h8040, 16'h8040, 16'ha000, 16'h8000};
  logic [3:0] gtab = 4'b0010, itab = 4'b1100, rtab = 4'b1010;
  int failures = 0, n_compared = 0, cyc = 0, k;
  ptc_top u_dut (.i_sys_clk, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_idle, .i_lo_ext_clk, .i_lo_gate,
    .i_hi_ext_clk, .i_hi_gate, .o_lo_match, .o_hi_match);
  ptc_pin_model u_lp (.o_clk(i_lo_ext_clk), .o_gate(i_lo_gate));
  ptc_pin_model u_hp (.o_clk(i_hi_ext_clk), .o_gate(i_hi_gate));
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int div(input int s);
    return (s == 3) ? 256 : (1 << (3 * s));
  endfunction
  function automatic logic [31:0] exp_ctrl(input logic [31:0] d, input logic hi);
    return {16'h0, d[15:0] & (hi ? PTC_HI_CTRL_MASK : PTC_LO_CTRL_MASK)};
  endfunction
  task automatic print_verdict();
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= ad;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_sys_clk);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] ad, input logic [31:0] exp);
    repeat (6) @(posedge i_sys_clk);
    apb(1'b0, ad, 32'h0);
    check(nm, rd, exp);
  endtask
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    {i_rst_b, i_psel, i_penable, i_pwrite, i_idle, i_paddr, i_pwdata} = '0;
    seed = 32'hf13d;
    repeat (3) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    rchk("lo_ctrl", PTC_OFF_LO_CTRL, 32'h0);
    rchk("hi_per", PTC_OFF_HI_PER, {16'h0, PTC_PER_RST});
    apb(1'b0, 8'h1c, 32'h0);
    check("slverr", {31'h0, e}, 32'h1);
    check("err_data", rd, 32'h0);
    for (int i = 0; i < 6; i++) begin
      v = xs() & 32'h7fff;
      a = i[0] ? PTC_OFF_HI_CTRL : PTC_OFF_LO_CTRL;
      apb(1'b1, a, v);
      rchk("ctrl_rb", a, exp_ctrl(v, i[0]));
    end
    // External clock, gate bit set but gate pin low
    for (int s = 0; s < 4; s++) begin
      k = 1 + int'(xs() % 32'd2);
      apb(1'b1, PTC_OFF_LO_CNT, 32'h0);
      apb(1'b1, PTC_OFF_LO_CTRL, 32'h8042 | (32'(s) << 4));
      u_lp.pulses(k * div(s));
      repeat (6) @(posedge i_sys_clk);
      apb(1'b1, PTC_OFF_LO_CTRL, 32'h0);
      rchk("ps_cnt", PTC_OFF_LO_CNT, 32'(k));
    end
    u_lp.pulses(3);
    rchk("stop_cnt", PTC_OFF_LO_CNT, 32'(k));
    apb(1'b1, PTC_OFF_LO_CNT, 32'h0);
    apb(1'b1, PTC_OFF_LO_CTRL, 32'h8012);
    u_lp.pulses(5);
    repeat (6) @(posedge i_sys_clk);
    apb(1'b1, PTC_OFF_LO_CTRL, 32'h8012);
    u_lp.pulses(3);
    rchk("ps_clear", PTC_OFF_LO_CNT, 32'h0);
    for (int c = 0; c < 4; c++) begin
      i_idle <= itab[c];
      u_lp.set_gate(gtab[c]);
      apb(1'b1, PTC_OFF_LO_CNT, 32'h0);
      apb(1'b1, PTC_OFF_LO_CTRL, {16'h0, ctab[c]});
      repeat (40) @(posedge i_sys_clk);
      apb(1'b1, PTC_OFF_LO_CTRL, 32'h0);
      apb(1'b0, PTC_OFF_LO_CNT, 32'h0);
      check("int_cnt", {31'h0, rd >= 32'd18 && rd <= 32'd24}, {31'h0, rtab[c]});
    end
    apb(1'b1, PTC_OFF_LO_PER, 32'h3);
    apb(1'b1, PTC_OFF_LO_CNT, 32'h0);
    apb(1'b1, PTC_OFF_LO_CTRL, 32'h8002);
    u_lp.pulses(4);
    rchk("wrap", PTC_OFF_LO_CNT, 32'h0);
    check("lo_flag", {31'h0, o_lo_match}, 32'h1);
    apb(1'b1, PTC_OFF_STATUS, 32'h3);
    check("flag_clr", {31'h0, o_lo_match}, 32'h0);
    apb(1'b1, PTC_OFF_LO_CTRL, 32'h0);
    apb(1'b1, PTC_OFF_LO_CNT, 32'hfffe);
    apb(1'b1, PTC_OFF_HI_CNT, 32'h0);
    apb(1'b1, PTC_OFF_LO_PER, 32'h1);
    apb(1'b1, PTC_OFF_HI_PER, 32'h1);
    apb(1'b1, PTC_OFF_LO_CTRL, 32'h800a);
    apb(1'b1, PTC_OFF_HI_CTRL, 32'h8032);
    u_hp.pulses(3);
    u_lp.pulses(3);
    rchk("pair_lo", PTC_OFF_LO_CNT, 32'h1);
    rchk("pair_hi", PTC_OFF_HI_CNT, 32'h1);
    u_lp.pulses(1);
    rchk("pair_wrap", PTC_OFF_LO_CNT, 32'h0);
    check("hi_flag", {30'h0, o_hi_match, o_lo_match}, 32'h2);
    apb(1'b1, PTC_OFF_LO_CTRL, 32'h0);
    apb(1'b1, PTC_OFF_HI_CNT, 32'h0);
    apb(1'b1, PTC_OFF_HI_CTRL, 32'h8002);
    u_hp.pulses(1);
    rchk("hi_alone", PTC_OFF_HI_CNT, 32'h1);
    // High timer alone, internal clock, gate pin at a random level
    apb(1'b1, PTC_OFF_HI_PER, {16'h0, PTC_PER_RST});
    for (int g = 0; g < 2; g++) begin
      v = xs() ^ 32'(g);
      u_hp.set_gate(v[0]);
      apb(1'b1, PTC_OFF_HI_CNT, 32'h0);
      apb(1'b1, PTC_OFF_HI_CTRL, 32'h8040);
      repeat (40) @(posedge i_sys_clk);
      apb(1'b1, PTC_OFF_HI_CTRL, 32'h0);
      apb(1'b0, PTC_OFF_HI_CNT, 32'h0);
      check("hi_gate", {31'h0, rd >= 32'd18 && rd <= 32'd24}, {31'h0, v[0]});
    end
    print_verdict();
  end
endmodule
`default_nettype wire
